//--- logic/vic_pkg.sv
package vic_pkg;

  // ==========================================================
  // direct address space
  // ==========================================================
  localparam logic [7:0] VIC_SFR_BASE = 8'h80;
  localparam logic [2:0] VIC_BITADDR_LOW3 = 3'h0;

  // ==========================================================
  // register offsets in the special function register space
  // ==========================================================
  localparam logic [7:0] VIC_ADDR_PRIMARY_ENABLE = 8'hA8;
  localparam logic [7:0] VIC_ADDR_PRIMARY_PRIORITY = 8'hB8;
  localparam logic [7:0] VIC_ADDR_EXTENDED_ENABLE = 8'hE6;
  localparam logic [7:0] VIC_ADDR_EXTENDED_PRIORITY = 8'hF6;

  // ==========================================================
  // reset values and writable masks
  // ==========================================================
  localparam logic [7:0] VIC_RST_PRIMARY_ENABLE = 8'h00;
  localparam logic [7:0] VIC_RST_PRIMARY_PRIORITY = 8'h00;
  localparam logic [7:0] VIC_RST_EXTENDED_ENABLE = 8'h00;
  localparam logic [7:0] VIC_RST_EXTENDED_PRIORITY = 8'h00;
  // bit 6 of the extended pair belongs to the reserved slot
  localparam logic [7:0] VIC_MASK_EXTENDED = 8'hBF;
  localparam logic [7:0] VIC_MASK_PRIMARY_PRIORITY = 8'h7F;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int VIC_GLOBAL_ENABLE_BIT = 7;
  localparam int VIC_NUM_SLOTS = 15;
  localparam logic [3:0] VIC_RESERVED_SLOT = 4'hD;

  // ==========================================================
  // vectors
  // ==========================================================
  localparam logic [15:0] VIC_RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VIC_VECTOR_BASE = 16'h0003;
  localparam int VIC_VECTOR_STEP_LOG2 = 3;

  // ==========================================================
  // pending conditions from the peripherals
  // ==========================================================
  typedef struct packed {
    logic ext_irq0_pending;
    logic timer0_overflow_flag;
    logic ext_irq1_pending;
    logic timer1_overflow_flag;
    logic uart_receive_flag;
    logic uart_transmit_flag;
    logic timer2_high_overflow_flag;
    logic timer2_low_overflow_flag;
    logic serial_periph_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic receive_overrun_flag;
    logic twowire_flag;
    logic port_match_live;
    logic adc_window_flag;
    logic adc_done_flag;
    logic counter_array_overflow_flag;
    logic [2:0] capture_compare_flag;
    logic cycle_overflow_flag;
    logic comparator_fall_flag;
    logic comparator_rise_flag;
    logic timer3_high_overflow_flag;
    logic timer3_low_overflow_flag;
  } vic_flags_t;

  // hardware-cleared flags, one pulse each
  typedef struct packed {
    logic timer1_overflow_flag;
    logic ext_irq1_pending;
    logic timer0_overflow_flag;
    logic ext_irq0_pending;
  } vic_hwclr_t;

  function automatic logic [15:0] vic_vector_of(input logic [3:0] slot);
    vic_vector_of = VIC_VECTOR_BASE + ({12'h000, slot} << VIC_VECTOR_STEP_LOG2);
  endfunction : vic_vector_of

  function automatic logic vic_bit_addressable(input logic [7:0] addr);
    vic_bit_addressable = (addr[2:0] == VIC_BITADDR_LOW3);
  endfunction : vic_bit_addressable

endpackage : vic_pkg

//--- logic/vic_prio_pick.sv
`timescale 1ns/1ps
module vic_prio_pick
  import vic_pkg::*;
(
  input wire logic [VIC_NUM_SLOTS-1:0] req_i,
  output logic valid_o,
  output logic [3:0] slot_o
);

  // lowest slot wins among requests of one level
  always_comb
  begin
    valid_o = 1'b0;
    slot_o = 4'h0;
    for (int i = VIC_NUM_SLOTS - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        valid_o = 1'b1;
        slot_o = 4'(i);
      end
    end
  end

endmodule : vic_prio_pick

//--- logic/vic_top.sv
`timescale 1ns/1ps
// Behaviour
// - after reset the first request offered is the reset entry at vector 0x0000, always enabled, above all, flagless.
// - source slot n branches to vector 0x0003 plus eight times n, reaching 0x0073 for slot 14.
// - among pending requests of one level the lowest slot number from 0 to 14 is served first.
// - the two external and two basic timer flags get a hardware clear pulse when their interrupt is taken.
// - primary enable bits 0 to 6 gate the original sources, extended enable bits gate the extended ones.
// - each source has one priority bit at the same position as its enable in the matching priority register.
// - the port match request follows its live condition gated by its enable, with no pending flag.
// - slot 13 is reserved and has no source, enable or priority bit.
// - the serial peripheral slot requests on the OR of done, collision, mode fault and overrun.
// - the counter array slot requests on counter overflow, any capture/compare flag or cycle overflow.
// - the comparator slot requests on fall or rise flag; those and timer 3 flags are not bit-addressable.
// - direct accesses to 0x80 through 0xFF go to the special function register space, below to RAM.
// - in the special function register space only addresses ending in 0x0 or 0x8 take single-bit access, others take whole bytes only.
module vic_top
  import vic_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic DIR_REQ_I,
  input wire logic [7:0] DIR_ADDR_I,
  input wire logic DIR_WR_I,
  input wire logic [7:0] DIR_WDATA_I,
  input wire logic DIR_BIT_I,
  input wire logic [2:0] DIR_BITSEL_I,
  input wire vic_flags_t SRC_FLAGS_I,
  input wire logic INT_ACK_I,
  input wire logic RETI_I,
  output logic [7:0] DIR_RDATA_O,
  output logic DIR_SFR_O,
  output logic DIR_RAM_O,
  output logic DIR_BIT_REFUSED_O,
  output logic INT_REQ_O,
  output logic [15:0] INT_VECTOR_O,
  output logic INT_HIGH_O,
  output logic [1:0] ACTIVE_LEVELS_O,
  output vic_hwclr_t FLAG_CLR_O
);

  // ==========================================================
  // registers
  // ==========================================================
  logic [7:0] primary_interrupt_enable_r;
  logic [7:0] primary_interrupt_priority_r;
  logic [7:0] extended_interrupt_enable_r;
  logic [7:0] extended_interrupt_priority_r;
  logic boot_pending_r, active_hi_r, active_lo_r, slot_is_boot_r;
  logic [3:0] slot_r;

  // ==========================================================
  // direct access decode
  // ==========================================================
  logic in_sfr, bit_ok, bit_refused, wr_en;
  logic [7:0] cur_byte, wr_byte;

  assign in_sfr = (DIR_ADDR_I >= VIC_SFR_BASE);
  assign bit_ok = vic_bit_addressable(DIR_ADDR_I);
  assign bit_refused = DIR_REQ_I && in_sfr && DIR_BIT_I && !bit_ok;
  assign wr_en = DIR_REQ_I && in_sfr && DIR_WR_I && !bit_refused;

  always_comb
  begin
    unique case (DIR_ADDR_I)
      VIC_ADDR_PRIMARY_ENABLE: cur_byte = primary_interrupt_enable_r;
      VIC_ADDR_PRIMARY_PRIORITY: cur_byte = primary_interrupt_priority_r;
      VIC_ADDR_EXTENDED_ENABLE: cur_byte = extended_interrupt_enable_r;
      VIC_ADDR_EXTENDED_PRIORITY: cur_byte = extended_interrupt_priority_r;
      // unoccupied or foreign addresses read as zero here
      default: cur_byte = 8'h00;
    endcase
  end

  // single-bit write is a read-modify-write of the owning byte
  always_comb
  begin
    wr_byte = DIR_WDATA_I;
    if (DIR_BIT_I)
    begin
      wr_byte = cur_byte;
      wr_byte[DIR_BITSEL_I] = DIR_WDATA_I[0];
    end
  end

  // ==========================================================
  // register writes
  // ==========================================================
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      primary_interrupt_enable_r <= VIC_RST_PRIMARY_ENABLE;
      primary_interrupt_priority_r <= VIC_RST_PRIMARY_PRIORITY;
      extended_interrupt_enable_r <= VIC_RST_EXTENDED_ENABLE;
      extended_interrupt_priority_r <= VIC_RST_EXTENDED_PRIORITY;
    end
    else if (CE_I && wr_en)
    begin
      // writes to any other address are dropped, no side effect
      if (DIR_ADDR_I == VIC_ADDR_PRIMARY_ENABLE)
        primary_interrupt_enable_r <= wr_byte;
      if (DIR_ADDR_I == VIC_ADDR_PRIMARY_PRIORITY)
        primary_interrupt_priority_r <= wr_byte & VIC_MASK_PRIMARY_PRIORITY;
      if (DIR_ADDR_I == VIC_ADDR_EXTENDED_ENABLE)
        extended_interrupt_enable_r <= wr_byte & VIC_MASK_EXTENDED;
      if (DIR_ADDR_I == VIC_ADDR_EXTENDED_PRIORITY)
        extended_interrupt_priority_r <= wr_byte & VIC_MASK_EXTENDED;
    end
  end

  // ==========================================================
  // access answer, one cycle after the request
  // ==========================================================
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      DIR_RDATA_O <= 8'h00;
      DIR_SFR_O <= 1'b0;
      DIR_RAM_O <= 1'b0;
      DIR_BIT_REFUSED_O <= 1'b0;
    end
    else if (CE_I)
    begin
      DIR_SFR_O <= DIR_REQ_I && in_sfr;
      DIR_RAM_O <= DIR_REQ_I && !in_sfr;
      DIR_BIT_REFUSED_O <= bit_refused;
      if (DIR_REQ_I && in_sfr && !DIR_WR_I && !bit_refused)
        DIR_RDATA_O <= DIR_BIT_I ? {7'h00, cur_byte[DIR_BITSEL_I]} : cur_byte;
      else
        DIR_RDATA_O <= 8'h00;
    end
  end

  // ==========================================================
  // per-slot requests
  // ==========================================================
  logic [VIC_NUM_SLOTS-1:0] pend, en, lvl, req;
  logic global_en;

  always_comb
  begin
    pend = '0;
    pend[0] = SRC_FLAGS_I.ext_irq0_pending;
    pend[1] = SRC_FLAGS_I.timer0_overflow_flag;
    pend[2] = SRC_FLAGS_I.ext_irq1_pending;
    pend[3] = SRC_FLAGS_I.timer1_overflow_flag;
    pend[4] = SRC_FLAGS_I.uart_receive_flag | SRC_FLAGS_I.uart_transmit_flag;
    pend[5] = SRC_FLAGS_I.timer2_high_overflow_flag | SRC_FLAGS_I.timer2_low_overflow_flag;
    pend[6] = SRC_FLAGS_I.serial_periph_done_flag | SRC_FLAGS_I.write_collision_flag
            | SRC_FLAGS_I.mode_fault_flag | SRC_FLAGS_I.receive_overrun_flag;
    pend[7] = SRC_FLAGS_I.twowire_flag;
    pend[8] = SRC_FLAGS_I.port_match_live;
    pend[9] = SRC_FLAGS_I.adc_window_flag;
    pend[10] = SRC_FLAGS_I.adc_done_flag;
    pend[11] = SRC_FLAGS_I.counter_array_overflow_flag | (|SRC_FLAGS_I.capture_compare_flag)
             | SRC_FLAGS_I.cycle_overflow_flag;
    pend[12] = SRC_FLAGS_I.comparator_fall_flag | SRC_FLAGS_I.comparator_rise_flag;
    pend[14] = SRC_FLAGS_I.timer3_high_overflow_flag | SRC_FLAGS_I.timer3_low_overflow_flag;
  end

  // reserved slot bit is masked to zero in the extended pair
  assign en = {extended_interrupt_enable_r, primary_interrupt_enable_r[6:0]};
  assign lvl = {extended_interrupt_priority_r, primary_interrupt_priority_r[6:0]};
  assign global_en = primary_interrupt_enable_r[VIC_GLOBAL_ENABLE_BIT];
  assign req = pend & en & {VIC_NUM_SLOTS{global_en}};

  logic hi_valid, lo_valid;
  logic [3:0] hi_slot, lo_slot;

  vic_prio_pick u_pick_hi
  (
    .req_i(req & lvl),
    .valid_o(hi_valid),
    .slot_o(hi_slot)
  );

  vic_prio_pick u_pick_lo
  (
    .req_i(req & ~lvl),
    .valid_o(lo_valid),
    .slot_o(lo_slot)
  );

  logic take_hi, take_lo, ack;

  assign take_hi = hi_valid && !active_hi_r;
  assign take_lo = lo_valid && !active_hi_r && !active_lo_r;
  assign ack = INT_ACK_I && INT_REQ_O;

  // ==========================================================
  // request offered to the core
  // ==========================================================
  // held low in the ack cycle so a stale choice is never offered twice
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      INT_REQ_O <= 1'b0;
      INT_VECTOR_O <= VIC_RESET_VECTOR;
      INT_HIGH_O <= 1'b0;
      slot_r <= 4'h0;
      slot_is_boot_r <= 1'b1;
    end
    else if (CE_I)
    begin
      if (ack)
        INT_REQ_O <= 1'b0;
      else if (boot_pending_r)
      begin
        INT_REQ_O <= 1'b1;
        INT_VECTOR_O <= VIC_RESET_VECTOR;
        INT_HIGH_O <= 1'b1;
        slot_is_boot_r <= 1'b1;
      end
      else if (take_hi || take_lo)
      begin
        // any high choice beats any low choice
        INT_REQ_O <= 1'b1;
        INT_VECTOR_O <= vic_vector_of(take_hi ? hi_slot : lo_slot);
        INT_HIGH_O <= take_hi;
        slot_r <= take_hi ? hi_slot : lo_slot;
        slot_is_boot_r <= 1'b0;
      end
      else
        INT_REQ_O <= 1'b0;
    end
  end

  // ==========================================================
  // reset entry and in-service levels
  // ==========================================================
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      boot_pending_r <= 1'b1;
    else if (CE_I && ack && slot_is_boot_r)
      boot_pending_r <= 1'b0;
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      active_hi_r <= 1'b0;
      active_lo_r <= 1'b0;
    end
    else if (CE_I)
    begin
      if (ack && !slot_is_boot_r)
      begin
        if (INT_HIGH_O)
          active_hi_r <= 1'b1;
        else
          active_lo_r <= 1'b1;
      end
      else if (RETI_I)
      begin
        // the return closes the innermost routine
        if (active_hi_r)
          active_hi_r <= 1'b0;
        else
          active_lo_r <= 1'b0;
      end
    end
  end

  assign ACTIVE_LEVELS_O = {active_hi_r, active_lo_r};

  // ==========================================================
  // hardware clear of edge/overflow flags
  // ==========================================================
  // other slots get no pulse; their flags stay for software to clear
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      FLAG_CLR_O <= '0;
    else if (CE_I)
    begin
      FLAG_CLR_O <= '0;
      if (ack && !slot_is_boot_r)
      begin
        FLAG_CLR_O.ext_irq0_pending <= (slot_r == 4'h0);
        FLAG_CLR_O.timer0_overflow_flag <= (slot_r == 4'h1);
        FLAG_CLR_O.ext_irq1_pending <= (slot_r == 4'h2);
        FLAG_CLR_O.timer1_overflow_flag <= (slot_r == 4'h3);
      end
    end
  end

endmodule : vic_top

//--- tb/tb.sv
`timescale 1ns/1ps
// ====
// bench
// ====
module tb
  import vic_pkg::*;
;
  logic clk = 1'b0;
  logic rst, ce, req, wr, bacc, reti, ack_en, ack, irq, hi, special_function_register, ram, bref;
  logic [7:0] addr, wd, rd;
  logic [2:0] bsel;
  logic [3:0] dly;
  logic [15:0] vec;
  logic [1:0] act;
  vic_flags_t set_f, clr_f, flags;
  vic_hwclr_t hclr;
  int err_total = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  vic_top vic_top_inst (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce), .DIR_REQ_I(req), .DIR_ADDR_I(addr),
    .DIR_WR_I(wr), .DIR_WDATA_I(wd), .DIR_BIT_I(bacc), .DIR_BITSEL_I(bsel), .SRC_FLAGS_I(flags),
    .INT_ACK_I(ack), .RETI_I(reti), .DIR_RDATA_O(rd), .DIR_SFR_O(special_function_register), .DIR_RAM_O(ram),
    .DIR_BIT_REFUSED_O(bref), .INT_REQ_O(irq), .INT_VECTOR_O(vec), .INT_HIGH_O(hi),
    .ACTIVE_LEVELS_O(act), .FLAG_CLR_O(hclr));
  vic_core_model vic_core_model_inst (.clk_i(clk), .rst_i(rst), .int_req_i(irq), .ack_en_i(ack_en),
    .ack_dly_i(dly), .set_i(set_f), .clr_i(clr_f), .hw_clr_i(hclr), .int_ack_o(ack), .flags_o(flags));
  // ====
  // helpers
  // ====
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wd <= d;
    bacc <= b;
    bsel <= s;
    @(posedge clk);
    req <= 1'b0;
    #1;
  endtask : acc
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 40)
      begin
        err_total++;
        summarize();
      end
    end
  endtask : wait_irq
  // needs ack enabled: checks the offer, then the clear pulse after it is taken
  task automatic want(input logic [15:0] v, input logic [3:0] c);
    wait_irq(1'b1);
    chk("vector", v, vec);
    wait_irq(1'b0);
    chk("hw clear", 16'(c), 16'(hclr));
  endtask : want
  task automatic pend(input vic_flags_t s, input vic_flags_t c);
    @(posedge clk);
    set_f <= s;
    clr_f <= c;
    @(posedge clk);
    set_f <= '0;
    clr_f <= '0;
  endtask : pend
  task automatic ret(input logic [1:0] a);
    @(posedge clk);
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
    #1;
    chk("levels", 16'(a), 16'(act));
  endtask : ret
  function automatic vic_flags_t flag_of(input int s, input logic alt);
    vic_flags_t f;
    f = '0;
    case (s)
      0: f.ext_irq0_pending = 1'b1;
      1: f.timer0_overflow_flag = 1'b1;
      2: f.ext_irq1_pending = 1'b1;
      3: f.timer1_overflow_flag = 1'b1;
      4: {f.uart_receive_flag, f.uart_transmit_flag} = alt ? 2'b01 : 2'b10;
      5: {f.timer2_high_overflow_flag, f.timer2_low_overflow_flag} = alt ? 2'b01 : 2'b10;
      6: {f.serial_periph_done_flag, f.write_collision_flag, f.mode_fault_flag, f.receive_overrun_flag} =
        alt ? 4'h3 : 4'hC;
      7: f.twowire_flag = 1'b1;
      8: f.port_match_live = 1'b1;
      9: f.adc_window_flag = 1'b1;
      10: f.adc_done_flag = 1'b1;
      11: {f.counter_array_overflow_flag, f.capture_compare_flag, f.cycle_overflow_flag} = alt ? 5'h05 : 5'h1A;
      12: {f.comparator_fall_flag, f.comparator_rise_flag} = alt ? 2'b01 : 2'b10;
      default: {f.timer3_high_overflow_flag, f.timer3_low_overflow_flag} = alt ? 2'b01 : 2'b10;
    endcase
    return f;
  endfunction : flag_of
  // ====
  // scenarios
  // ====
  task automatic t_regs;
    logic [7:0] ra [4];
    logic [7:0] rm [4];
    ra = '{VIC_ADDR_PRIMARY_ENABLE, VIC_ADDR_PRIMARY_PRIORITY, VIC_ADDR_EXTENDED_ENABLE, VIC_ADDR_EXTENDED_PRIORITY};
    rm = '{8'hFF, VIC_MASK_PRIMARY_PRIORITY, VIC_MASK_EXTENDED, VIC_MASK_EXTENDED};
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b0, ra[i], 8'h00, 1'b0, 3'h0);
      chk("reset value", 16'h0000, 16'(rd));
      acc(1'b1, ra[i], 8'hFF, 1'b0, 3'h0);
      acc(1'b0, ra[i], 8'h00, 1'b0, 3'h0);
      chk("readback", 16'(rm[i]), 16'(rd));
      chk("sfr pulse", 16'h0001, 16'(special_function_register));
    end
    // owned by another block; unoccupied addresses are left alone
    acc(1'b1, 8'hB1, 8'hFF, 1'b0, 3'h0);
    acc(1'b0, 8'hB1, 8'h00, 1'b0, 3'h0);
    chk("foreign", 16'h0000, 16'(rd));
    acc(1'b0, 8'h7F, 8'h00, 1'b0, 3'h0);
    chk("ram pulse", 16'h0002, 16'({ram, special_function_register}));
    acc(1'b1, VIC_ADDR_PRIMARY_ENABLE, 8'h00, 1'b1, 3'h7);
    acc(1'b0, VIC_ADDR_PRIMARY_ENABLE, 8'h00, 1'b0, 3'h0);
    chk("bit write", 16'h007F, 16'(rd));
    acc(1'b0, VIC_ADDR_PRIMARY_PRIORITY, 8'h00, 1'b1, 3'h6);
    chk("bit read", 16'h0001, 16'(rd));
    acc(1'b1, VIC_ADDR_EXTENDED_ENABLE, 8'h00, 1'b1, 3'h0);
    chk("bit refused", 16'h0001, 16'(bref));
    acc(1'b0, VIC_ADDR_EXTENDED_ENABLE, 8'h00, 1'b0, 3'h0);
    chk("kept byte", 16'h00BF, 16'(rd));
    @(posedge clk);
    ce <= 1'b0;
    acc(1'b1, VIC_ADDR_PRIMARY_PRIORITY, 8'h00, 1'b0, 3'h0);
    chk("frozen answer", 16'h0000, 16'(special_function_register));
    @(posedge clk);
    ce <= 1'b1;
    acc(1'b0, VIC_ADDR_PRIMARY_PRIORITY, 8'h00, 1'b0, 3'h0);
    chk("frozen write", 16'h007F, 16'(rd));
    $display("t_regs done");
  endtask : t_regs
  task automatic t_vec;
    vic_flags_t f;
    acc(1'b1, VIC_ADDR_PRIMARY_ENABLE, 8'hFF, 1'b0, 3'h0);
    acc(1'b1, VIC_ADDR_PRIMARY_PRIORITY, 8'h00, 1'b0, 3'h0);
    acc(1'b1, VIC_ADDR_EXTENDED_PRIORITY, 8'h00, 1'b0, 3'h0);
    for (int a = 0; a < 2; a++)
      for (int s = 0; s < 15; s++)
      begin
        if (s == 13)
          continue;
        f = flag_of(s, a[0]);
        @(posedge clk);
        dly <= a[0] ? 4'h3 : 4'h0;
        pend(f, '0);
        want(VIC_VECTOR_BASE + 16'(8 * s), s < 4 ? 4'h1 << s : 4'h0);
        @(posedge clk);
        #1;
        chk("pending kept", 16'(s >= 4), 16'(|flags));
        chk("levels", 16'h0001, 16'(act));
        pend('0, f);
        ret(2'b00);
      end
    $display("t_vec done");
  endtask : t_vec
  task automatic t_prio;
    vic_flags_t f;
    f = flag_of(2, 1'b0) | flag_of(5, 1'b0);
    @(posedge clk);
    ack_en <= 1'b0;
    acc(1'b1, VIC_ADDR_PRIMARY_ENABLE, 8'h7F, 1'b0, 3'h0);
    pend(f, '0);
    repeat (4) @(posedge clk);
    #1;
    chk("global off", 16'h0000, 16'(irq));
    acc(1'b1, VIC_ADDR_PRIMARY_ENABLE, 8'hFF, 1'b0, 3'h0);
    wait_irq(1'b1);
    chk("tie break", 16'h0013, vec);
    chk("low level", 16'h0000, 16'(hi));
    @(posedge clk);
    ack_en <= 1'b1;
    want(16'h0013, 4'h4);
    acc(1'b1, VIC_ADDR_EXTENDED_PRIORITY, 8'h04, 1'b0, 3'h0);
    pend(flag_of(9, 1'b0), '0);
    wait_irq(1'b1);
    chk("high level", 16'h0001, 16'(hi));
    want(16'h004B, 4'h0);
    repeat (4) @(posedge clk);
    #1;
    chk("held off", 16'h0000, 16'(irq));
    pend('0, flag_of(9, 1'b0));
    ret(2'b01);
    ret(2'b00);
    want(16'h002B, 4'h0);
    pend('0, f);
    ret(2'b00);
    $display("t_prio done");
  endtask : t_prio
  initial
  begin
    {rst, ce, ack_en} = 3'b111;
    {req, wr, bacc, reti, addr, wd, bsel, dly} = '0;
    set_f = '0;
    clr_f = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    want(VIC_RESET_VECTOR, 4'h0);
    t_regs();
    t_vec();
    t_prio();
    summarize();
  end
endmodule : tb

//--- tb/vic_core_model.sv
`timescale 1ns/1ps
// ====
// core and peripheral stand-in
// ====
module vic_core_model
  import vic_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic int_req_i,
  input wire logic ack_en_i,
  input wire logic [3:0] ack_dly_i,
  input wire vic_flags_t set_i,
  input wire vic_flags_t clr_i,
  input wire vic_hwclr_t hw_clr_i,
  output logic int_ack_o,
  output vic_flags_t flags_o
);
  logic [3:0] wait_r;
  // ack held until sampled with the request, then released
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      int_ack_o <= 1'b0;
      wait_r <= 4'h0;
    end
    else if (int_ack_o || !int_req_i)
    begin
      int_ack_o <= 1'b0;
      wait_r <= 4'h0;
    end
    else if (ack_en_i && wait_r >= ack_dly_i)
      int_ack_o <= 1'b1;
    else
      wait_r <= wait_r + 4'h1;
  end
  // only the four pulsed flags drop on service; the rest wait for software
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      flags_o <= '0;
    else
      flags_o <= (flags_o | set_i) & ~clr_i & ~{hw_clr_i.ext_irq0_pending, hw_clr_i.timer0_overflow_flag,
        hw_clr_i.ext_irq1_pending, hw_clr_i.timer1_overflow_flag, 21'h0};
  end
endmodule : vic_core_model

//--- tb/vic_top_assertions.sv
`timescale 1ns/1ps
// ====
// port checks
// ====
module vic_top_assertions
  import vic_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic DIR_REQ_I,
  input wire logic [7:0] DIR_ADDR_I,
  input wire logic DIR_BIT_I,
  input wire logic INT_ACK_I,
  input wire logic [7:0] DIR_RDATA_O,
  input wire logic DIR_SFR_O,
  input wire logic DIR_RAM_O,
  input wire logic DIR_BIT_REFUSED_O,
  input wire logic INT_REQ_O,
  input wire logic [15:0] INT_VECTOR_O,
  input wire logic INT_HIGH_O,
  input wire logic [1:0] ACTIVE_LEVELS_O,
  input wire vic_hwclr_t FLAG_CLR_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  wire logic taken = INT_ACK_I && INT_REQ_O && CE_I;
  property p_boot;
    $fell(RST_I) |-> ##[0:1] (INT_REQ_O && INT_VECTOR_O == 16'h0000 && INT_HIGH_O);
  endproperty
  a_boot: assert property (p_boot) else $error("reset entry missing");
  property p_vec;
    INT_REQ_O && INT_VECTOR_O != 16'h0000 |-> INT_VECTOR_O[2:0] == 3'h3 && INT_VECTOR_O <= 16'h0073
      && INT_VECTOR_O != 16'h006B;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_drop;
    taken |=> !INT_REQ_O;
  endproperty
  a_drop: assert property (p_drop) else $error("request not dropped");
  property p_lvl;
    taken && INT_VECTOR_O != 16'h0000 |=> ACTIVE_LEVELS_O[$past(INT_HIGH_O)];
  endproperty
  a_lvl: assert property (p_lvl) else $error("level not marked");
  property p_lowwait;
    INT_REQ_O && !INT_HIGH_O |-> ACTIVE_LEVELS_O == 2'b00;
  endproperty
  a_lowwait: assert property (p_lowwait) else $error("low offered too early");
  property p_hinest;
    INT_REQ_O && INT_HIGH_O && INT_VECTOR_O != 16'h0000 |-> !ACTIVE_LEVELS_O[1];
  endproperty
  a_hinest: assert property (p_hinest) else $error("high nested in high");
  property p_clr;
    taken |=> FLAG_CLR_O == (($past(INT_VECTOR_O) - 16'h0003) <= 16'h0018 ?
      4'h1 << $past(INT_VECTOR_O[4:3]) : 4'h0);
  endproperty
  a_clr: assert property (p_clr) else $error("wrong clear pulse");
  property p_clr1;
    FLAG_CLR_O != 4'h0 && CE_I |=> FLAG_CLR_O == 4'h0;
  endproperty
  a_clr1: assert property (p_clr1) else $error("clear pulse too long");
  property p_space;
    DIR_REQ_I && CE_I |=> DIR_SFR_O == ($past(DIR_ADDR_I) >= 8'h80) && DIR_RAM_O == ($past(DIR_ADDR_I) < 8'h80);
  endproperty
  a_space: assert property (p_space) else $error("wrong space");
  property p_bitref;
    DIR_REQ_I && CE_I && DIR_BIT_I && DIR_ADDR_I[7] && DIR_ADDR_I[2:0] != 3'h0
      |=> DIR_BIT_REFUSED_O && DIR_RDATA_O == 8'h00;
  endproperty
  a_bitref: assert property (p_bitref) else $error("bit access not refused");
endmodule : vic_top_assertions

bind vic_top vic_top_assertions vic_top_assertions_inst (.CORE_CLK_I, .RST_I, .CE_I, .DIR_REQ_I, .DIR_ADDR_I,
  .DIR_BIT_I, .INT_ACK_I, .DIR_RDATA_O, .DIR_SFR_O, .DIR_RAM_O, .DIR_BIT_REFUSED_O, .INT_REQ_O,
  .INT_VECTOR_O, .INT_HIGH_O, .ACTIVE_LEVELS_O, .FLAG_CLR_O);
